// ---- hw/bcc_pkg.sv ----
package bcc_pkg;

  // ==========================================================================
  // Widths and timing-free constants.
  localparam int VW = 13;
  localparam int IW = 12;
  localparam int BW = 8;
  localparam int AW = 8;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_FLOAT = 8'h04;
  localparam logic [AW-1:0] ADDR_VFAST = 8'h08;
  localparam logic [AW-1:0] ADDR_RECHG = 8'h0C;
  localparam logic [AW-1:0] ADDR_DERATE = 8'h10;
  localparam logic [AW-1:0] ADDR_ICHG = 8'h14;
  localparam logic [AW-1:0] ADDR_ILIM = 8'h18;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h1C;

  // Control register bit positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SPK_BIT = 1;
  localparam int CTRL_EXT_BIT = 2;

  // ==========================================================================
  // Voltage figures in mV, then the percent divisor, the current target shifts and the base drive codes.
  localparam logic [VW-1:0] VFLOAT_BASE_MV = 13'h0E42;
  localparam logic [VW-1:0] VFLOAT_STEP_MV = 13'h0032;
  localparam logic [VW-1:0] VFLOAT_MAX_MV = 13'h1130;
  localparam logic [VW-1:0] HYST_PRE_MV = 13'h0064;
  localparam logic [VW-1:0] HYST_FAST_MV = 13'h00C8;
  localparam logic [VW-1:0] VPRE_MV_DEF = 13'h0B54;
  localparam logic [19:0] PCT_DIV = 20'h00064;
  localparam int PRE_SHIFT = 3;
  localparam int TRICKLE_SHIFT = 5;
  localparam logic [BW-1:0] BASE_SAFE_DEF = 8'h40;
  localparam logic [BW-1:0] BASE_MAX = 8'hFF;

  // Reset values.
  localparam logic [3:0] FLOAT_RST = 4'hB;
  localparam logic [VW-1:0] VFAST_RST = 13'h0BB8;
  localparam logic [6:0] RECHG_RST = 7'h05;
  localparam logic [IW-1:0] ICHG_RST = 12'h0C8;
  localparam logic [IW-1:0] ILIM_RST = 12'h1F4;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_OFF, ST_TRICKLE, ST_PRE, ST_FAST_CC, ST_FAST_CV, ST_STANDBY
  } bcc_state_e;

  typedef struct packed {
    logic enable;
    logic speaker;
    logic ext_pnp;
    logic [3:0] float_code;
    logic [3:0] derate;
    logic [VW-1:0] vfast;
    logic [6:0] rechg_pct;
    logic [IW-1:0] ichg;
    logic [IW-1:0] ilim;
  } bcc_cfg_s;

endpackage

// ---- hw/bcc_ctrl.sv ----
// The implementer's own choices: the APB interface to the registers and the register offsets.
module bcc_ctrl #(
  parameter logic [bcc_pkg::VW-1:0] VPRE_MV = bcc_pkg::VPRE_MV_DEF,
  parameter logic [bcc_pkg::BW-1:0] BASE_SAFE = bcc_pkg::BASE_SAFE_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bcc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog sense, asynchronous.
  input wire logic [bcc_pkg::VW-1:0] bat_mv,
  input wire logic [bcc_pkg::IW-1:0] charge_current_sense,
  input wire logic term_reached,
  input wire logic charger_supply_low,
  // Analog control.
  output logic [bcc_pkg::IW-1:0] current_target,
  output logic [bcc_pkg::VW-1:0] float_target_mv,
  output logic cv_regulate,
  output logic input_limit_en,
  output logic sys_from_supply,
  output logic [bcc_pkg::BW-1:0] base_drive
);
  import bcc_pkg::*;

  // ==========================================================================
  // Registers and bus decode.
  bcc_cfg_s cfg_q;
  bcc_state_e st_q, st_d;
  logic [VW-1:0] bat_s1_q, bat_s2_q, bat_s3_q, bat_q;
  logic [IW-1:0] isn_s1_q, isn_s2_q, isn_s3_q, isn_q;
  logic term_s1_q, term_q, low_s1_q, low_q;
  logic [IW-1:0] tgt_q;
  logic [VW-1:0] vfl_q;
  logic cv_q, ilim_en_q, sysup_q;
  logic [BW-1:0] base_q, base_d;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_float = (paddr == ADDR_FLOAT);
  wire hit_vfast = (paddr == ADDR_VFAST);
  wire hit_rechg = (paddr == ADDR_RECHG);
  wire hit_derate = (paddr == ADDR_DERATE);
  wire hit_ichg = (paddr == ADDR_ICHG);
  wire hit_ilim = (paddr == ADDR_ILIM);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_any = hit_ctrl | hit_float | hit_vfast | hit_rechg | hit_derate | hit_ichg | hit_ilim | hit_status;

  // Zero wait states; unmapped addresses answer with an error and zero data.
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  wire [31:0] rd_ctrl = {29'h0, cfg_q.ext_pnp, cfg_q.speaker, cfg_q.enable};
  wire [31:0] rd_float = {28'h0, cfg_q.float_code};
  wire [31:0] rd_vfast = {19'h0, cfg_q.vfast};
  wire [31:0] rd_rechg = {25'h0, cfg_q.rechg_pct};
  wire [31:0] rd_derate = {28'h0, cfg_q.derate};
  wire [31:0] rd_ichg = {20'h0, cfg_q.ichg};
  wire [31:0] rd_ilim = {20'h0, cfg_q.ilim};
  // Status word: state in the low bits, then cv, synchronised supply low and the accepted battery word.
  wire [31:0] rd_status = {14'h0, bat_q, low_q, cv_q, st_q};
  assign prdata = hit_ctrl ? rd_ctrl :
                  hit_float ? rd_float :
                  hit_vfast ? rd_vfast :
                  hit_rechg ? rd_rechg :
                  hit_derate ? rd_derate :
                  hit_ichg ? rd_ichg :
                  hit_ilim ? rd_ilim :
                  hit_status ? rd_status : 32'h0;

  // Enable clears at reset so the charger sits off until software acts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{enable: 1'b0, speaker: 1'b0, ext_pnp: 1'b0, float_code: FLOAT_RST, derate: 4'h0,
                 vfast: VFAST_RST, rechg_pct: RECHG_RST, ichg: ICHG_RST, ilim: ILIM_RST};
    end else if (wr) begin
      if (hit_ctrl) begin
        cfg_q.enable <= pwdata[CTRL_EN_BIT];
        cfg_q.speaker <= pwdata[CTRL_SPK_BIT];
        cfg_q.ext_pnp <= pwdata[CTRL_EXT_BIT];
      end
      if (hit_float) cfg_q.float_code <= pwdata[3:0];
      if (hit_vfast) cfg_q.vfast <= pwdata[VW-1:0];
      if (hit_rechg) cfg_q.rechg_pct <= pwdata[6:0];
      if (hit_derate) cfg_q.derate <= pwdata[3:0];
      if (hit_ichg) cfg_q.ichg <= pwdata[IW-1:0];
      if (hit_ilim) cfg_q.ilim <= pwdata[IW-1:0];
    end
  end

  // ==========================================================================
  // Input synchronisers.
  // Sense words are only accepted after two equal synchronised samples, so a word caught mid-change
  // never reaches the comparators; the cost is two extra cycles of latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bat_s1_q <= '0;
      bat_s2_q <= '0;
      bat_s3_q <= '0;
      bat_q <= '0;
      isn_s1_q <= '0;
      isn_s2_q <= '0;
      isn_s3_q <= '0;
      isn_q <= '0;
      term_s1_q <= 1'b0;
      term_q <= 1'b0;
      low_s1_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      bat_s1_q <= bat_mv;
      bat_s2_q <= bat_s1_q;
      bat_s3_q <= bat_s2_q;
      if (bat_s2_q == bat_s3_q) bat_q <= bat_s3_q;
      isn_s1_q <= charge_current_sense;
      isn_s2_q <= isn_s1_q;
      isn_s3_q <= isn_s2_q;
      if (isn_s2_q == isn_s3_q) isn_q <= isn_s3_q;
      term_s1_q <= term_reached;
      term_q <= term_s1_q;
      low_s1_q <= charger_supply_low;
      low_q <= low_s1_q;
    end
  end

  // ==========================================================================
  // Thresholds.
  wire [3:0] eff_code = (cfg_q.float_code > cfg_q.derate) ? cfg_q.float_code - cfg_q.derate : 4'h0;
  wire [VW-1:0] vfloat = VFLOAT_BASE_MV + VW'(VFLOAT_STEP_MV * eff_code);
  wire [19:0] rechg_prod = 20'(vfloat) * 20'(cfg_q.rechg_pct);
  wire [VW-1:0] rechg_drop = VW'(rechg_prod / PCT_DIV);
  wire [VW-1:0] rechg_thr = (vfloat > rechg_drop) ? vfloat - rechg_drop : '0;
  wire [VW-1:0] vpre_lo = (VPRE_MV > HYST_PRE_MV) ? VPRE_MV - HYST_PRE_MV : '0;
  wire [VW-1:0] vfast_lo = (cfg_q.vfast > HYST_FAST_MV) ? cfg_q.vfast - HYST_FAST_MV : '0;

  // ==========================================================================
  // Charge state machine, one step per cycle.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: if (cfg_q.enable) st_d = ST_TRICKLE;
      ST_TRICKLE: if (bat_q >= VPRE_MV) st_d = ST_PRE;
      ST_PRE: begin
        if (bat_q < vpre_lo) st_d = ST_TRICKLE;
        else if (bat_q >= cfg_q.vfast) st_d = ST_FAST_CC;
      end
      ST_FAST_CC: begin
        if (bat_q < vfast_lo) st_d = ST_PRE;
        else if (bat_q >= vfloat) st_d = ST_FAST_CV;
      end
      ST_FAST_CV: if (term_q) st_d = ST_STANDBY;
      ST_STANDBY: if (bat_q < rechg_thr) st_d = ST_FAST_CC;
      default: st_d = ST_OFF;
    endcase
    if (!cfg_q.enable) st_d = ST_OFF;
  end

  // ==========================================================================
  // Current target and mode outputs.
  wire [IW-1:0] tgt_state = (st_d == ST_TRICKLE) ? cfg_q.ichg >> TRICKLE_SHIFT :
                            (st_d == ST_PRE) ? cfg_q.ichg >> PRE_SHIFT :
                            (st_d == ST_FAST_CC || st_d == ST_FAST_CV) ? cfg_q.ichg : '0;
  // Speaker mode caps what is drawn from the supply; the battery covers the load peaks.
  wire [IW-1:0] tgt_d = (cfg_q.speaker && tgt_state > cfg_q.ilim) ? cfg_q.ilim : tgt_state;

  // Base drive steps one code per cycle, a slow loop; it clears at once without ext_pnp or a target and caps at BASE_SAFE on low supply.
  always_comb begin
    base_d = base_q;
    if (!cfg_q.ext_pnp || tgt_q == '0) base_d = '0;
    else if (isn_q < tgt_q && base_q != BASE_MAX) base_d = base_q + 8'h01;
    else if (isn_q > tgt_q && base_q != '0) base_d = base_q - 8'h01;
    if (low_q && base_d > BASE_SAFE) base_d = BASE_SAFE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_OFF;
      tgt_q <= '0;
      vfl_q <= VFLOAT_BASE_MV;
      cv_q <= 1'b0;
      ilim_en_q <= 1'b0;
      sysup_q <= 1'b0;
      base_q <= '0;
    end else begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      vfl_q <= vfloat;
      cv_q <= (st_d == ST_FAST_CV);
      ilim_en_q <= cfg_q.enable && cfg_q.speaker;
      sysup_q <= cfg_q.enable && !cfg_q.speaker;
      base_q <= base_d;
    end
  end

  assign current_target = tgt_q;
  assign float_target_mv = vfl_q;
  assign cv_regulate = cv_q;
  assign input_limit_en = ilim_en_q;
  assign sys_from_supply = sysup_q;
  assign base_drive = base_q;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disable_off: assert property (!cfg_q.enable |=> st_q == ST_OFF)
    else $error("charger not off while disabled");
  a_trickle_up: assert property (st_q == ST_TRICKLE && cfg_q.enable && bat_q >= VPRE_MV |=> st_q == ST_PRE)
    else $error("trickle did not move to pre-charge");
  a_pre_down: assert property (st_q == ST_PRE && cfg_q.enable && bat_q < vpre_lo |=> st_q == ST_TRICKLE)
    else $error("pre-charge did not fall back to trickle");
  a_fast_down: assert property (st_q == ST_FAST_CC && cfg_q.enable && bat_q < vfast_lo |=> st_q == ST_PRE)
    else $error("fast charge did not fall back");
  a_cv_term: assert property (st_q == ST_FAST_CV && cfg_q.enable && term_q |=> st_q == ST_STANDBY && tgt_q == '0)
    else $error("termination did not reach standby");
  a_stby_rechg: assert property (st_q == ST_STANDBY && cfg_q.enable && bat_q < rechg_thr |=> st_q == ST_FAST_CC)
    else $error("standby did not restart fast charge");
  a_stby_idle: assert property (st_q == ST_STANDBY && $past(st_q) == ST_STANDBY |-> tgt_q == '0 && base_q == '0)
    else $error("current driven in standby");
  a_base_clamp: assert property (low_q |=> base_q <= BASE_SAFE)
    else $error("base drive above safe limit");
  a_float_range: assert property (vfl_q >= VFLOAT_BASE_MV && vfl_q <= VFLOAT_MAX_MV)
    else $error("float voltage out of range");
  a_spk_limit: assert property (cfg_q.speaker |=> tgt_q <= $past(cfg_q.ilim))
    else $error("speaker mode target above input limit");

  // ==========================================================================
  // Assertions on holding and leaving a state.
  // Every state must stay put while its exit compares are false; a missing hold
  // check would let a chattering threshold compare go unnoticed.
  a_trickle_hold: assert property (st_q == ST_TRICKLE && cfg_q.enable && bat_q < VPRE_MV
    |=> st_q == ST_TRICKLE)
    else $error("trickle left below the pre-charge threshold");
  a_pre_hold: assert property (st_q == ST_PRE && cfg_q.enable && bat_q >= vpre_lo && bat_q < cfg_q.vfast
    |=> st_q == ST_PRE)
    else $error("pre-charge left inside its band");
  a_pre_up: assert property (st_q == ST_PRE && cfg_q.enable && bat_q >= vpre_lo && bat_q >= cfg_q.vfast
    |=> st_q == ST_FAST_CC)
    else $error("pre-charge did not reach fast charge");
  a_cc_hold: assert property (st_q == ST_FAST_CC && cfg_q.enable && bat_q >= vfast_lo && bat_q < vfloat
    |=> st_q == ST_FAST_CC)
    else $error("constant current left inside its band");
  a_cc_to_cv: assert property (st_q == ST_FAST_CC && cfg_q.enable && bat_q >= vfast_lo && bat_q >= vfloat
    |=> st_q == ST_FAST_CV)
    else $error("constant current did not reach constant voltage");
  a_cv_hold: assert property (st_q == ST_FAST_CV && cfg_q.enable && !term_q
    |=> st_q == ST_FAST_CV)
    else $error("constant voltage left before termination");
  a_stby_hold: assert property (st_q == ST_STANDBY && cfg_q.enable && bat_q >= rechg_thr
    |=> st_q == ST_STANDBY)
    else $error("standby left above the recharge threshold");

  // ==========================================================================
  // Assertions on targets and drive.
  // Targets are held against the configuration one cycle back, because the
  // target register samples it together with the next state.
  a_off_quiet: assert property (st_q == ST_OFF
    |-> tgt_q == '0 && !cv_q)
    else $error("charge requested while off");
  a_trickle_amp: assert property (st_q == ST_TRICKLE && !$past(cfg_q.speaker)
    |-> tgt_q == ($past(cfg_q.ichg) >> TRICKLE_SHIFT))
    else $error("trickle target wrong");
  a_pre_amp: assert property (st_q == ST_PRE && !$past(cfg_q.speaker)
    |-> tgt_q == ($past(cfg_q.ichg) >> PRE_SHIFT))
    else $error("pre-charge target wrong");
  a_fast_amp: assert property ((st_q == ST_FAST_CC || st_q == ST_FAST_CV) && !$past(cfg_q.speaker)
    |-> tgt_q == $past(cfg_q.ichg))
    else $error("fast charge target wrong");
  a_headset_mode: assert property (cfg_q.enable && !cfg_q.speaker
    |=> sys_from_supply && !input_limit_en)
    else $error("headset mode flags wrong");
  a_speaker_mode: assert property (cfg_q.enable && cfg_q.speaker
    |=> input_limit_en && !sys_from_supply)
    else $error("speaker mode flags wrong");
  a_base_up: assert property (cfg_q.ext_pnp && tgt_q != '0 && !low_q && isn_q < tgt_q && base_q != BASE_MAX
    |=> base_q == $past(base_q) + 8'h01)
    else $error("base drive did not step up");
  a_base_down: assert property (cfg_q.ext_pnp && tgt_q != '0 && !low_q && isn_q > tgt_q && base_q != '0
    |=> base_q == $past(base_q) - 8'h01)
    else $error("base drive did not step down");
  a_base_off: assert property (!cfg_q.ext_pnp
    |=> base_q == '0)
    else $error("base driven without external transistor");

  // ==========================================================================
  // Assertions on float and sense inputs.
  // The accepted battery word must not move while the synchronised copies disagree.
  a_float_derate: assert property (cfg_q.derate >= cfg_q.float_code
    |=> vfl_q == VFLOAT_BASE_MV)
    else $error("derated float voltage did not floor");
  a_sync_hold: assert property (bat_s2_q != bat_s3_q
    |=> bat_q == $past(bat_q))
    else $error("unsettled battery word accepted");

endmodule // bcc_ctrl

// ---- sim/bcc_batt_model.sv ----
// ============================================================================
// Cell and supply sense model.
module bcc_batt_model (
  // Clock.
  pclk,
  // Requested conditions.
  v_set,
  i_set,
  term_set,
  low_set,
  // Sense outputs.
  bat_mv,
  cur_mv,
  term_out,
  low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic pclk;
  input wire logic [12:0] v_set;
  input wire logic [11:0] i_set;
  input wire logic term_set;
  input wire logic low_set;
  output logic [12:0] bat_mv = 13'h0000;
  output logic [11:0] cur_mv = 12'h000;
  output logic term_out = 1'b0;
  output logic low_out = 1'b0;
  // Outputs move just after an edge, as a sampled converter would, so the
  // controller always sees a whole word change at once.
  always @(posedge pclk) begin
    bat_mv <= v_set;
    cur_mv <= i_set;
    term_out <= term_set;
    low_out <= low_set;
  end
endmodule // bcc_batt_model

// ---- sim/tb.sv ----
// ============================================================================
// Charger controller bench.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bcc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [VW-1:0] bat_mv, float_target_mv, v_set = 13'h0000;
  logic [IW-1:0] cur, current_target, i_set = 12'h000;
  logic term, low, cv_regulate, input_limit_en, sys_from_supply, term_set = 0, low_set = 0;
  logic [BW-1:0] base_drive, b;
  int n_mismatch = 0, cmp_count = 0, ichg, spk = 0;
  always #25 pclk = ~pclk;
  bcc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bat_mv(bat_mv),
    .charge_current_sense(cur), .term_reached(term), .charger_supply_low(low),
    .current_target(current_target), .float_target_mv(float_target_mv), .cv_regulate(cv_regulate),
    .input_limit_en(input_limit_en), .sys_from_supply(sys_from_supply), .base_drive(base_drive));
  bcc_batt_model batt_u (.pclk(pclk), .v_set(v_set), .i_set(i_set), .term_set(term_set),
    .low_set(low_set), .bat_mv(bat_mv), .cur_mv(cur), .term_out(term), .low_out(low));
  task stop_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: no ready", $time);
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(r, exp);
  endtask
  function automatic int tgt(bcc_state_e s);
    int t;
    t = (s == ST_TRICKLE) ? ichg >> 5 : (s == ST_PRE) ? ichg >> 3 : (s inside {ST_FAST_CC, ST_FAST_CV}) ? ichg : 0;
    return (spk != 0 && t > 100) ? 100 : t;
  endfunction
  // A stay case waits out the synchroniser and filter before looking.
  task go(input int v, input bcc_state_e s, input bit stay);
    int i;
    v_set <= v[12:0];
    i = 0;
    if (stay) repeat (10) @(posedge pclk);
    do begin
      apb(0, ADDR_STATUS, 32'h0);
      i++;
    end while (r[2:0] !== s && i < 30);
    chk(r[2:0], s);
    chk(current_target, tgt(s));
  endtask
  initial begin
    void'($urandom(32'hF077DD3E));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_FLOAT, 32'hB);
    rd_chk(ADDR_VFAST, 32'hBB8);
    rd_chk(ADDR_RECHG, 32'h5);
    rd_chk(ADDR_STATUS, 32'h0);
    apb(0, 8'h20, 32'h0);
    chk(e, 1'b1);
    chk(current_target, 32'h0);
    $display("test reset done");
    ichg = 400 + $urandom % 1001;
    apb(1, ADDR_ICHG, ichg);
    apb(1, ADDR_VFAST, 32'hD48);
    apb(1, ADDR_CTRL, 32'h1);
    go(2000, ST_TRICKLE, 0);
    go(2950, ST_PRE, 0);
    go(2850, ST_PRE, 1);
    go(2790, ST_TRICKLE, 0);
    go(3000, ST_PRE, 0);
    go(3400, ST_FAST_CC, 0);
    go(3250, ST_FAST_CC, 1);
    go(3150, ST_PRE, 0);
    go(3500, ST_FAST_CC, 0);
    go(4200, ST_FAST_CV, 0);
    chk(cv_regulate, 1'b1);
    chk(r[3], 1'b1);
    term_set <= 1;
    go(4200, ST_STANDBY, 0);
    chk(base_drive, 32'h0);
    term_set <= 0;
    go(4000, ST_STANDBY, 1);
    chk(r[17:5], 13'hFA0);
    go(3985, ST_FAST_CC, 0);
    $display("test charge done");
    apb(1, ADDR_ILIM, 32'h64);
    spk = 1;
    apb(1, ADDR_CTRL, 32'h3);
    go(3985, ST_FAST_CC, 1);
    chk({input_limit_en, sys_from_supply}, 2'b10);
    spk = 0;
    apb(1, ADDR_CTRL, 32'h5);
    go(3985, ST_FAST_CC, 1);
    chk({input_limit_en, sys_from_supply}, 2'b01);
    b = base_drive;
    @(posedge pclk);
    chk(base_drive, b + 8'h01);
    i_set <= 12'hFFF;
    repeat (8) @(posedge pclk);
    b = base_drive;
    @(posedge pclk);
    chk(base_drive, b - 8'h01);
    i_set <= 12'h000;
    repeat (300) @(posedge pclk);
    low_set <= 1;
    repeat (250) @(posedge pclk);
    chk(base_drive, BASE_SAFE_DEF);
    low_set <= 0;
    $display("test modes done");
    for (int c = 0; c < 16; c++) begin
      apb(1, ADDR_FLOAT, c);
      @(posedge pclk);
      chk(float_target_mv, 3650 + 50 * c);
    end
    apb(1, ADDR_DERATE, 32'h3);
    @(posedge pclk);
    chk(float_target_mv, 32'd4250);
    apb(1, ADDR_FLOAT, 32'h1);
    @(posedge pclk);
    chk(float_target_mv, 32'd3650);
    apb(1, ADDR_CTRL, 32'h0);
    go(3985, ST_OFF, 0);
    $display("test float done");
    stop_test();
  end
endmodule // tb
